// ---- design/tcrm_regmap.sv ----
// Register map of the tuner control front end with its serial slave port.
// Assumes CLK runs at least eight times faster than SCLK and that SCLK and
// SDATA_I arrive from pins asynchronous to CLK.
`include "tcrm_consts.svh"
`default_nettype none
module tcrm_regmap
   import tcrm_pkg::*;
#(
   parameter logic [3:0] SID0_RST     = 4'h1,
   parameter logic [3:0] SID1_RST     = 4'h2,
   parameter logic [3:0] SID2_RST     = 4'h3,
   parameter logic [9:0] MAKER_CODE   = 10'h2a5, // Arbitrary value.
   parameter logic [6:0] PROD_FIXED   = 7'h15,   // Arbitrary value.
   parameter logic [7:0] TEST_PATTERN = 8'ha5
)(
   input  wire logic      CLK,
   input  wire logic      NRST,
   input  wire logic      SCLK,
   input  wire logic      SDATA_I,
   output var  logic      SDATA_O,
   output var  logic      SDATA_OE,
   input  wire logic      OTP_PID_BIT,
   output var  tcrm_cfg_t CFG
);

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic sclk_m_r, sclk_s_r, sclk_d_r;
   logic sd_m_r, sd_s_r, sd_d_r;
   logic otp_m_r, otp_s_r;

   // SCLK, SDATA_I and OTP_PID_BIT pass two flops; SCLK and SDATA_I get a third for edge detection.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         sclk_m_r <= 1'b0;
         sclk_s_r <= 1'b0;
         sclk_d_r <= 1'b0;
         sd_m_r   <= 1'b0;
         sd_s_r   <= 1'b0;
         sd_d_r   <= 1'b0;
         otp_m_r  <= 1'b0;
         otp_s_r  <= 1'b0;
      end else begin
         sclk_m_r <= SCLK;
         sclk_s_r <= sclk_m_r;
         sclk_d_r <= sclk_s_r;
         sd_m_r   <= SDATA_I;
         sd_s_r   <= sd_m_r;
         sd_d_r   <= sd_s_r;
         otp_m_r  <= OTP_PID_BIT;
         otp_s_r  <= otp_m_r;
      end
   end

   // Edges of the link clock and data, all seen after synchronisation.
   wire logic sclk_fall = sclk_d_r & ~sclk_s_r;
   wire logic sclk_rise = ~sclk_d_r & sclk_s_r;
   wire logic sd_rise   = ~sd_d_r & sd_s_r;
   wire logic sd_fall   = sd_d_r & ~sd_s_r;

   // ----------------------------------------------------------------
   // Sequence start detection
   // ----------------------------------------------------------------
   logic ssc_arm_r;

   // A start is data rising then falling while the clock stays low. Our
   // own read drive is masked so that it can never look like a start.
   wire logic ssc = ssc_arm_r & sd_fall & ~sclk_s_r & ~SDATA_OE;

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         ssc_arm_r <= 1'b0;
      end else if (sclk_s_r || SDATA_OE || ssc) begin
         ssc_arm_r <= 1'b0;
      end else if (sd_rise) begin
         ssc_arm_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Register storage declarations
   // ----------------------------------------------------------------
   logic [6:0]  ctrl0_r;
   logic [7:0]  route_r, boost_r, dual_r, group_r, status_r;
   logic [3:0]  sid_r [0:2];
   logic [1:0]  power_state_field_r;
   logic [2:0]  trigger_mask_r;
   logic [7:0]  active_w [0:`TCRM_SHD_N-1];
   logic [3:0]  sa_r;
   logic [7:0]  addr_r, wa_r, wd_r;
   logic        wr_r, wz_r;

   // ----------------------------------------------------------------
   // Identifier matching and access qualification
   // ----------------------------------------------------------------
   // Returns {broadcast, id2, id1, id0}; the group id counts as broadcast.
   function automatic logic [3:0] id_match(input logic [3:0] sa);
      id_match = {(sa == `TCRM_BCAST_SID) || (sa == group_r[3:0]),
                  sa == sid_r[2], sa == sid_r[1], sa == sid_r[0]};
   endfunction : id_match

   // Select code 3 means any of the three own ids, else one of them.
   function automatic logic sel_ok(input logic [1:0] sel, input logic [3:0] m);
      sel_ok = (sel == `TCRM_SEL_ANY) ? |m[2:0] : m[sel];
   endfunction : sel_ok

   // Whether an address answers to the frame's identifier at all.
   function automatic logic acc_ok(input logic [7:0] a, input logic [3:0] m,
                                   input logic [7:0] route);
      logic [7:0] lane;
      lane = a - `TCRM_A_VAL_LO;
      case (a)
         `TCRM_A_SID1:   acc_ok = m[1] | m[3];
         `TCRM_A_SID2:   acc_ok = m[2] | m[3];
         `TCRM_A_SID0:   acc_ok = m[0] | m[3];
         `TCRM_A_PMTRIG: acc_ok = |m;
         `TCRM_A_STATUS, `TCRM_A_GROUP, `TCRM_A_PROD, `TCRM_A_MAKER,
         `TCRM_A_GROUP2, `TCRM_A_SOFTRST, `TCRM_A_ERRSUM,
         `TCRM_A_PATTERN: acc_ok = |m[2:0];
         default: begin
            if (a >= `TCRM_A_VAL_LO && a <= `TCRM_A_SHD_HI) begin
               acc_ok = sel_ok(route[{lane[1:0], 1'b0} +: 2], m);
            end else if (a <= `TCRM_A_DUAL) begin
               acc_ok = |m[2:0];
            end else begin
               acc_ok = 1'b0;
            end
         end
      endcase
   endfunction : acc_ok

   wire logic [3:0] idm_w = id_match(sa_r);

   // ----------------------------------------------------------------
   // Read selection
   // ----------------------------------------------------------------
   logic [7:0] rd_raw;
   wire logic [3:0] shd_idx = 4'(addr_r - `TCRM_A_SHD_LO);

   // Unmapped, spare and reserved addresses read zero.
   always_comb begin
      rd_raw = 8'h00;
      case (addr_r)
         `TCRM_A_CTRL0:   rd_raw = {1'b0, ctrl0_r};
         `TCRM_A_ROUTE:   rd_raw = route_r;
         `TCRM_A_BOOST:   rd_raw = boost_r;
         `TCRM_A_DUAL:    rd_raw = dual_r;
         `TCRM_A_SID0:    rd_raw = {2'b00, MAKER_CODE[9:8], sid_r[0]};
         `TCRM_A_SID1:    rd_raw = {2'b00, MAKER_CODE[9:8], sid_r[1]};
         `TCRM_A_SID2:    rd_raw = {2'b00, MAKER_CODE[9:8], sid_r[2]};
         `TCRM_A_STATUS,
         `TCRM_A_ERRSUM:  rd_raw = status_r;
         `TCRM_A_GROUP,
         `TCRM_A_GROUP2:  rd_raw = group_r;
         `TCRM_A_PMTRIG:  rd_raw = {power_state_field_r, trigger_mask_r, 3'b000};
         `TCRM_A_PROD:    rd_raw = {PROD_FIXED, otp_s_r};
         `TCRM_A_MAKER:   rd_raw = MAKER_CODE[7:0];
         `TCRM_A_PATTERN: rd_raw = TEST_PATTERN;
         default: begin
            if (addr_r >= `TCRM_A_SHD_LO && addr_r <= `TCRM_A_SHD_HI) begin
               rd_raw = active_w[shd_idx];
            end
         end
      endcase
   end

   wire logic [7:0] rd_w = acc_ok(addr_r, idm_w, route_r) ? rd_raw : 8'h00;

   // ----------------------------------------------------------------
   // Write qualification
   // ----------------------------------------------------------------
   // Read-only addresses never take a write.
   wire logic ro_w = (wa_r == `TCRM_A_PROD) || (wa_r == `TCRM_A_MAKER) ||
                     (wa_r == `TCRM_A_ERRSUM) || (wa_r == `TCRM_A_PATTERN);
   wire logic wr_ok = wr_r & ~ro_w & (wz_r | acc_ok(wa_r, idm_w, route_r));
   wire logic err_acc = wr_r & ~wr_ok;

   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = wr_ok && (wa_r == a);
   endfunction : wr_hit

   // Soft reset and a move into start-up mode both clear the user registers.
   wire logic user_rst = (wr_hit(`TCRM_A_SOFTRST) && wd_r[`TCRM_SOFTRST_BIT]) ||
                         (wr_hit(`TCRM_A_PMTRIG) && wd_r[7:6] == `TCRM_PM_STARTUP);

   // ----------------------------------------------------------------
   // Frame engine
   // ----------------------------------------------------------------
   tcrm_state_t state_r, state_nxt;
   logic [3:0]  cnt_r, cnt_nxt;
   logic [4:0]  bytes_r, bytes_nxt;
   logic [12:0] sh_r, sh_nxt;
   logic [7:0]  addr_nxt, wa_nxt, wd_nxt, st_ev;
   logic [3:0]  sa_nxt;
   logic        rd_r, rd_nxt, wr_nxt, wz_nxt, out_r, out_nxt, oe_r, oe_nxt;

   wire logic [12:0] frm = {sh_r[11:0], sd_s_r};
   wire logic [7:0]  cmd = frm[8:1];
   wire logic [3:0]  idf = id_match(frm[12:9]);

   // Bits are taken on link clock falls and read data leaves on rises.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      bytes_nxt = bytes_r;
      addr_nxt  = addr_r;
      sh_nxt    = sh_r;
      sa_nxt    = sa_r;
      rd_nxt    = rd_r;
      wa_nxt    = wa_r;
      wd_nxt    = wd_r;
      wr_nxt    = 1'b0;
      wz_nxt    = 1'b0;
      out_nxt   = out_r;
      oe_nxt    = oe_r;
      st_ev     = 8'h00;
      if (ssc) begin
         state_nxt = TCRM_CMD;
         cnt_nxt   = 4'h0;
         out_nxt   = 1'b0;
         oe_nxt    = 1'b0;
      end else begin
         case (state_r)
            TCRM_CMD: begin
               if (sclk_fall) begin
                  sh_nxt  = frm;
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == `TCRM_CMD_LAST) begin
                     state_nxt = TCRM_IDLE;
                     cnt_nxt   = 4'h0;
                     sa_nxt    = frm[12:9];
                     if (!(^frm)) begin
                        st_ev[`TCRM_ST_CPAR] = 1'b1;
                     end else if (idf == 4'h0) begin
                        state_nxt = TCRM_IDLE;
                     end else if (cmd[7]) begin
                        wr_nxt = 1'b1;
                        wz_nxt = 1'b1;
                        wa_nxt = `TCRM_A_CTRL0;
                        wd_nxt = {1'b0, cmd[6:0]};
                     end else if (cmd[7:5] == `TCRM_OP_WR) begin
                        addr_nxt  = {3'b000, cmd[4:0]};
                        bytes_nxt = 5'h01;
                        rd_nxt    = 1'b0;
                        state_nxt = TCRM_WDATA;
                     end else if (cmd[7:5] == `TCRM_OP_RD) begin
                        addr_nxt  = {3'b000, cmd[4:0]};
                        bytes_nxt = 5'h01;
                        rd_nxt    = 1'b1;
                        state_nxt = (|idf[2:0]) ? TCRM_RPARK : TCRM_IDLE;
                     end else if (cmd[7:4] == `TCRM_OP_EXTWR) begin
                        bytes_nxt = {1'b0, cmd[3:0]} + 5'h01;
                        rd_nxt    = 1'b0;
                        state_nxt = TCRM_ADDR;
                     end else if (cmd[7:4] == `TCRM_OP_EXTRD) begin
                        bytes_nxt = {1'b0, cmd[3:0]} + 5'h01;
                        rd_nxt    = 1'b1;
                        state_nxt = (|idf[2:0]) ? TCRM_ADDR : TCRM_IDLE;
                     end else if (cmd[7:3] == `TCRM_OP_LONGWR) begin
                        st_ev[`TCRM_ST_WLONG] = 1'b1;
                     end else if (cmd[7:3] == `TCRM_OP_LONGRD) begin
                        st_ev[`TCRM_ST_RLONG] = 1'b1;
                     end
                  end
               end
            end
            TCRM_ADDR: begin
               if (sclk_fall) begin
                  sh_nxt  = frm;
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == `TCRM_FRM_LAST) begin
                     cnt_nxt = 4'h0;
                     if (!(^frm[8:0])) begin
                        st_ev[`TCRM_ST_DPAR] = 1'b1;
                        state_nxt = TCRM_IDLE;
                     end else begin
                        addr_nxt  = frm[8:1];
                        state_nxt = rd_r ? TCRM_RPARK : TCRM_WDATA;
                     end
                  end
               end
            end
            TCRM_WDATA: begin
               if (sclk_fall) begin
                  sh_nxt  = frm;
                  cnt_nxt = cnt_r + 4'h1;
                  if (cnt_r == `TCRM_FRM_LAST) begin
                     cnt_nxt = 4'h0;
                     if (!(^frm[8:0])) begin
                        st_ev[`TCRM_ST_DPAR] = 1'b1;
                        state_nxt = TCRM_IDLE;
                     end else begin
                        wr_nxt    = 1'b1;
                        wa_nxt    = addr_r;
                        wd_nxt    = frm[8:1];
                        addr_nxt  = addr_r + 8'h01;
                        bytes_nxt = bytes_r - 5'h01;
                        if (bytes_r == 5'h01) begin
                           state_nxt = TCRM_IDLE;
                        end
                     end
                  end
               end
            end
            TCRM_RPARK: begin
               if (sclk_fall) begin
                  state_nxt = TCRM_RDATA;
                  cnt_nxt   = 4'h0;
                  sh_nxt    = {4'h0, rd_w, ~^rd_w};
               end
            end
            TCRM_RDATA: begin
               if (sclk_rise) begin
                  oe_nxt = 1'b1;
                  if (cnt_r != `TCRM_BYTE_DONE) begin
                     out_nxt = sh_r[8];
                     sh_nxt  = {sh_r[11:0], 1'b0};
                     cnt_nxt = cnt_r + 4'h1;
                     if (cnt_r == `TCRM_FRM_LAST) begin
                        addr_nxt = addr_r + 8'h01;
                     end
                  end else if (bytes_r > 5'h01) begin
                     bytes_nxt = bytes_r - 5'h01;
                     out_nxt   = rd_w[7];
                     sh_nxt    = {4'h0, rd_w[6:0], ~^rd_w, 1'b0};
                     cnt_nxt   = 4'h1;
                  end else begin
                     out_nxt   = 1'b0;
                     state_nxt = TCRM_REND;
                  end
               end
            end
            TCRM_REND: begin
               if (sclk_fall) begin
                  oe_nxt    = 1'b0;
                  state_nxt = TCRM_IDLE;
               end
            end
            default: begin
               state_nxt = TCRM_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         state_r <= TCRM_IDLE;
         cnt_r   <= 4'h0;
         bytes_r <= 5'h00;
         addr_r  <= 8'h00;
         sh_r    <= 13'h0000;
         sa_r    <= 4'h0;
         rd_r    <= 1'b0;
         wr_r    <= 1'b0;
         wz_r    <= 1'b0;
         wa_r    <= 8'h00;
         wd_r    <= 8'h00;
         out_r   <= 1'b0;
         oe_r    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         bytes_r <= bytes_nxt;
         addr_r  <= addr_nxt;
         sh_r    <= sh_nxt;
         sa_r    <= sa_nxt;
         rd_r    <= rd_nxt;
         wr_r    <= wr_nxt;
         wz_r    <= wz_nxt;
         wa_r    <= wa_nxt;
         wd_r    <= wd_nxt;
         out_r   <= out_nxt;
         oe_r    <= oe_nxt;
      end
   end

   // ----------------------------------------------------------------
   // User registers
   // ----------------------------------------------------------------
   // Bit 7 of register zero is not stored, so it always reads zero.
   always_ff @(posedge CLK) begin
      if (!NRST || user_rst) begin
         ctrl0_r <= `TCRM_RST_CTRL0;
         route_r <= `TCRM_RST_ROUTE;
         boost_r <= `TCRM_RST_BOOST;
         dual_r  <= 8'h00;
      end else begin
         if (wr_hit(`TCRM_A_CTRL0)) ctrl0_r <= wd_r[6:0];
         if (wr_hit(`TCRM_A_ROUTE)) route_r <= wd_r;
         if (wr_hit(`TCRM_A_BOOST)) boost_r <= wd_r;
         if (wr_hit(`TCRM_A_DUAL))  dual_r  <= wd_r;
      end
   end

   // Shadow and active pairs; a write lands in the shadow and moves to the
   // active copy on a trigger, or at once when its trigger is masked.
   for (genvar i = 0; i < `TCRM_SHD_N; i++) begin : g_shd
      localparam logic [7:0] RV = (i == 0) ? `TCRM_RST_GLIDE :
                                  (i == 1) ? `TCRM_RST_TURBO : 8'h00;
      wire logic [1:0] sel = (i < 3) ? `TCRM_SEL_ANY : route_r[((i + 1) % 4) * 2 +: 2];
      wire logic we   = wr_hit(8'(`TCRM_A_SHD_LO + i));
      wire logic imm  = ~sel_ok(sel, {1'b0, ~trigger_mask_r});
      wire logic fire = wr_hit(`TCRM_A_PMTRIG) &&
                        sel_ok(sel, {1'b0, wd_r[2:0] & ~wd_r[5:3]});
      logic [7:0] shd_r, act_r;
      always_ff @(posedge CLK) begin
         if (!NRST || user_rst) begin
            shd_r <= RV;
            act_r <= RV;
         end else begin
            if (we) shd_r <= wd_r;
            if (we && imm) act_r <= wd_r;
            else if (fire) act_r <= shd_r;
         end
      end
      assign active_w[i] = act_r;
   end

   // ----------------------------------------------------------------
   // Protocol registers
   // ----------------------------------------------------------------
   // Both group addresses write the one register.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         sid_r[0]            <= SID0_RST;
         sid_r[1]            <= SID1_RST;
         sid_r[2]            <= SID2_RST;
         group_r             <= 8'h00;
         power_state_field_r <= 2'h0;
         trigger_mask_r      <= 3'h0;
      end else begin
         if (wr_hit(`TCRM_A_SID0)) sid_r[0] <= wd_r[3:0];
         if (wr_hit(`TCRM_A_SID1)) sid_r[1] <= wd_r[3:0];
         if (wr_hit(`TCRM_A_SID2)) sid_r[2] <= wd_r[3:0];
         if (wr_hit(`TCRM_A_GROUP) || wr_hit(`TCRM_A_GROUP2)) group_r <= wd_r;
         if (wr_hit(`TCRM_A_PMTRIG)) begin
            power_state_field_r <= wd_r[7:6];
            trigger_mask_r      <= wd_r[5:3];
         end
      end
   end

   // Status flags are sticky; a write clears them but a new event wins.
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         status_r <= 8'h00;
      end else begin
         status_r <= (wr_hit(`TCRM_A_STATUS) ? 8'h00 : status_r) | st_ev |
                     {3'b000, err_acc, 4'h0};
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign SDATA_O  = out_r;
   assign SDATA_OE = oe_r;

   assign CFG.dac_en            = ctrl0_r[3:0];
   assign CFG.ext_jump          = ctrl0_r[4];
   assign CFG.pad_slew          = ctrl0_r[5];
   assign CFG.id_route          = route_r;
   assign CFG.boost             = boost_r;
   assign CFG.glide             = active_w[0];
   assign CFG.turbo             = active_w[1];
   assign CFG.dacs_ctrl         = active_w[2];
   assign CFG.first_radio       = {active_w[6], active_w[5], active_w[4], active_w[3]};
   assign CFG.second_radio      = {active_w[10], active_w[9], active_w[8], active_w[7]};
   assign CFG.dual_radio        = dual_r;
   assign CFG.power_state_field = power_state_field_r;

endmodule : tcrm_regmap
`default_nettype wire

// ---- design/tcrm_consts.svh ----
// Constants of the tuner control register map: addresses, fields, resets.
// Included by bare name ahead of the package user; holds definitions only.
`ifndef TCRM_CONSTS_SVH
`define TCRM_CONSTS_SVH
`define TCRM_A_CTRL0     8'h00
`define TCRM_A_ROUTE     8'h01
`define TCRM_A_BOOST     8'h02
`define TCRM_A_SHD_LO    8'h03
`define TCRM_A_VAL_LO    8'h06
`define TCRM_A_SHD_HI    8'h0d
`define TCRM_A_DUAL      8'h0e
`define TCRM_A_SID1      8'h18
`define TCRM_A_SID2      8'h19
`define TCRM_A_STATUS    8'h1a
`define TCRM_A_GROUP     8'h1b
`define TCRM_A_PMTRIG    8'h1c
`define TCRM_A_PROD      8'h1d
`define TCRM_A_MAKER     8'h1e
`define TCRM_A_SID0      8'h1f
`define TCRM_A_GROUP2    8'h22
`define TCRM_A_SOFTRST   8'h23
`define TCRM_A_ERRSUM    8'h24
`define TCRM_A_PATTERN   8'h2c
`define TCRM_SHD_N       11
`define TCRM_RST_CTRL0   7'h00
`define TCRM_RST_ROUTE   8'hff
`define TCRM_RST_BOOST   8'h5d
`define TCRM_RST_GLIDE   8'h0f
`define TCRM_RST_TURBO   8'h0f
`define TCRM_PM_STARTUP  2'h1
`define TCRM_SOFTRST_BIT 0
`define TCRM_ST_CPAR     0
`define TCRM_ST_DPAR     1
`define TCRM_ST_WLONG    2
`define TCRM_ST_RLONG    3
`define TCRM_ST_ACCESS   4
`define TCRM_BCAST_SID   4'h0
`define TCRM_SEL_ANY     2'h3
`define TCRM_CMD_LAST    4'hc
`define TCRM_FRM_LAST    4'h8
`define TCRM_BYTE_DONE   4'h9
`define TCRM_OP_WR       3'h2
`define TCRM_OP_RD       3'h3
`define TCRM_OP_EXTWR    4'h0
`define TCRM_OP_EXTRD    4'h2
`define TCRM_OP_LONGWR   5'h06
`define TCRM_OP_LONGRD   5'h07
`endif

// ---- design/tcrm_pkg.sv ----
// Types shared by the tuner control register map and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tcrm_pkg;
   typedef enum logic [6:0] {
      TCRM_IDLE  = 7'h01,
      TCRM_CMD   = 7'h02,
      TCRM_ADDR  = 7'h04,
      TCRM_WDATA = 7'h08,
      TCRM_RPARK = 7'h10,
      TCRM_RDATA = 7'h20,
      TCRM_REND  = 7'h40
   } tcrm_state_t;

   typedef struct packed {
      logic [3:0]      dac_en;
      logic            ext_jump;
      logic            pad_slew;
      logic [7:0]      id_route;
      logic [7:0]      boost;
      logic [7:0]      glide;
      logic [7:0]      turbo;
      logic [7:0]      dacs_ctrl;
      logic [3:0][7:0] first_radio;
      logic [3:0][7:0] second_radio;
      logic [7:0]      dual_radio;
      logic [1:0]      power_state_field;
   } tcrm_cfg_t;
endpackage : tcrm_pkg
`default_nettype wire

// ---- verification/tcrm_regmap_props.sv ----
// Checker for the register map: pin timing and reset values.
// Assumes CLK runs far faster than SCLK, as the map itself requires.
`default_nettype none
module tcrm_regmap_props
   import tcrm_pkg::*;
(
   input wire logic      CLK,
   input wire logic      NRST,
   input wire logic      SCLK,
   input wire logic      SDATA_O,
   input wire logic      SDATA_OE,
   input wire tcrm_cfg_t CFG
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   // Reset contents show at the first sample after release.
   chk_rst_pins: assert property ($rose(NRST) |-> !SDATA_OE && !SDATA_O)
      else $error("pins active after reset");
   chk_rst_route: assert property ($rose(NRST) |-> CFG.id_route == 8'hff)
      else $error("routing reset wrong");
   chk_rst_boost: assert property ($rose(NRST) |-> CFG.boost == 8'h5d)
      else $error("boost reset wrong");
   chk_rst_dacs: assert property ($rose(NRST) |-> CFG.first_radio == '0 && CFG.dac_en == '0)
      else $error("dac reset wrong");
   // The device drives only in step with SCLK rises, and never for long.
   chk_oe_rise: assert property ($rose(SDATA_OE) |-> SCLK)
      else $error("drive started off a rise");
   chk_data_step: assert property ($changed(SDATA_O) |-> SCLK)
      else $error("data moved while SCLK low");
   chk_oe_bound: assert property ($rose(SDATA_OE) |-> ##[1:300] !SDATA_OE)
      else $error("drive held too long");
   // Writes land just after a fall, so a long high SCLK sees no change.
   chk_cfg_hold: assert property (SCLK [*8] |-> $stable(CFG))
      else $error("config moved mid bit");
endmodule : tcrm_regmap_props
bind tcrm_regmap tcrm_regmap_props u_props(.CLK(CLK), .NRST(NRST), .SCLK(SCLK),
   .SDATA_O(SDATA_O), .SDATA_OE(SDATA_OE), .CFG(CFG));
`default_nettype wire

// ---- verification/tcrm_host.sv ----
// Serial bus master model: framing, odd parity, read turnaround, bus park.
// Assumes the device samples on SCLK falls and drives on SCLK rises.
`default_nettype none
module tcrm_host (
   output var logic SCLK,
   output var logic SDATA_I,
   input wire logic SDATA_O,
   input wire logic SDATA_OE
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv = 1'b0;
   logic en  = 1'b1;
   // A released wire shows our inverted last bit, so no stale level passes.
   assign SDATA_I = SDATA_OE ? SDATA_O : (en ? drv : ~drv);
   initial SCLK = 1'b0;
   task automatic put(input logic b);
      SCLK = 1'b1;
      drv = b;
      #80 SCLK = 1'b0;
      #80;
   endtask : put
   task automatic frm(input logic [11:0] d, input int n);
      for (int i = n - 1; i >= 0; i--) put(d[i]);
      put(~^d); // Odd parity.
   endtask : frm
   // Mode bit 0 reads, bit 1 adds an address frame, bit 2 drops the payload.
   task automatic xfer(input logic [3:0] sa, input logic [7:0] c, a, w,
                       input logic [2:0] m, output logic [8:0] q);
      q = 9'h000;
      drv = 1'b1;
      #40 drv = 1'b0;
      #40 frm({sa, c}, 12);
      if (m[1]) frm({4'h0, a}, 8);
      if (m[0]) begin
         put(1'b0);
         repeat (9) begin
            SCLK = 1'b1;
            en = 1'b0;
            #80 q = {q[7:0], SDATA_I};
            SCLK = 1'b0;
            #80;
         end
         SCLK = 1'b1;
         #80 SCLK = 1'b0;
         en = 1'b1;
         drv = 1'b0;
      end else begin
         if (!m[2]) frm({4'h0, w}, 8);
         put(1'b0);
      end
      #160;
   endtask : xfer
endmodule : tcrm_host
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the register map, driven through the host model.
// Assumes the host model's timing of one link bit per 160 ns.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [9:0] MK = 10'h2a5; // Arbitrary value.
   logic clk = 1'b0, nrst = 1'b0, otp = 1'b0, sclk, sdi, sdo, sdoe;
   tcrm_pkg::tcrm_cfg_t cfg;
   int error_cnt = 0, cmp_count = 0, cyc = 0;
   logic [8:0] q;
   logic [7:0] v;
   tcrm_regmap #(.MAKER_CODE(MK)) u_tcrm_regmap(.CLK(clk), .NRST(nrst), .SCLK(sclk),
      .SDATA_I(sdi), .SDATA_O(sdo), .SDATA_OE(sdoe), .OTP_PID_BIT(otp), .CFG(cfg));
   tcrm_host u_host(.SCLK(sclk), .SDATA_I(sdi), .SDATA_O(sdo), .SDATA_OE(sdoe));
   initial forever #4 clk = ~clk;
   // A hang is cut short well beyond the roughly 22500 cycles of the run.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         summarize();
      end
   end
   function automatic logic [7:0] idreg(input logic [3:0] s);
      return {2'b00, MK[9:8], s};
   endfunction : idreg
   task automatic check(input logic [7:0] s, e);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask : check
   task automatic wr(input logic [3:0] sa, input logic [7:0] a, d);
      u_host.xfer(sa, a < 8'h20 ? 8'h40 | a : 8'h00, a, d, a < 8'h20 ? 3'd0 : 3'd2, q);
   endtask : wr
   // Reads also confirm the parity bit that follows the data.
   task automatic rd(input logic [3:0] sa, input logic [7:0] a, e);
      u_host.xfer(sa, a < 8'h20 ? 8'h60 | a : 8'h20, a, 8'h00, a < 8'h20 ? 3'd1 : 3'd3, q);
      check(q[8:1], e);
      check({7'h00, q[0]}, {7'h00, ~^q[8:1]});
   endtask : rd
   task automatic summarize;
      $display("mismatches %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      v = 8'($urandom(77));
      otp = v[0];
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      check(cfg.id_route, 8'hff);
      rd(4'h1, 8'h1e, MK[7:0]);
      rd(4'h3, 8'h19, idreg(4'h3));
      rd(4'h2, 8'h1d, {7'h15, otp});
      rd(4'h1, 8'h2c, 8'ha5);
      v = 8'($urandom);
      wr(4'h1, 8'h1b, {4'h0, v[3:0]});
      rd(4'h1, 8'h22, {4'h0, v[3:0]});
      wr(4'h1, 8'h1e, v);
      wr(4'h2, 8'h11, v);
      rd(4'h1, 8'h1e, MK[7:0]);
      rd(4'h1, 8'h11, 8'h00);
      rd(4'h1, 8'h30, 8'h00);
      wr(4'h3, 8'h18, 8'h07);
      rd(4'h2, 8'h18, idreg(4'h2));
      rd(4'h1, 8'h1a, 8'h10);
      rd(4'h1, 8'h24, 8'h10);
      for (int k = 0; k < 4; k++) begin
         v = 8'($urandom);
         wr(4'h1, 8'h06 + k[7:0], v);
         rd(4'h1, 8'h06 + k[7:0], 8'h00);
         wr(4'h0, 8'h1c, 8'h07);
         rd(4'h1, 8'h06 + k[7:0], v);
         check(cfg.first_radio[k], v);
      end
      wr(4'h1, 8'h01, 8'h55);
      wr(4'h1, 8'h0a, 8'h3c);
      wr(4'h2, 8'h0a, 8'hc3);
      wr(4'h0, 8'h1c, 8'h07);
      rd(4'h2, 8'h0a, 8'hc3);
      check(cfg.second_radio[0], 8'hc3);
      u_host.xfer(4'h3, {2'b10, v[5:0]}, 8'h00, 8'h00, 3'd4, q);
      rd(4'h3, 8'h00, {2'b00, v[5:0]});
      check({2'b00, cfg.pad_slew, cfg.ext_jump, cfg.dac_en}, {2'b00, v[5:0]});
      wr(4'h1, 8'h02, v);
      wr(4'h1, 8'h23, 8'h01);
      rd(4'h1, 8'h02, 8'h5d);
      check(cfg.first_radio[0], 8'h00);
      wr(4'h1, 8'h02, v);
      wr(4'h0, 8'h1c, 8'h40);
      rd(4'h1, 8'h02, 8'h5d);
      check({6'h00, cfg.power_state_field}, 8'h01);
      summarize();
   end
endmodule : testbench
`default_nettype wire
